/* File: rtl/sew_pkg.sv */
// Purpose: Shared constants and types for the two-wire serial memory slave.
// Assumes: 50 MHz system clock; 32-bit AXI4-Lite register port.
// Notes: Timing counts are derived from their printed times here.
package sew_pkg;

	// System clock and self-timed programming period
	localparam int SEW_CLK_HZ = 50000000;
	localparam int SEW_PROG_PERIOD_US = 5000;
	localparam int SEW_CLK_PER_US = SEW_CLK_HZ / 1000000;
	// Longest time, rounded down to whole cycles
	localparam int SEW_PROG_CYC = SEW_PROG_PERIOD_US * SEW_CLK_PER_US;

	// Array organisation
	localparam int SEW_BYTE_BITS = 8;
	localparam int SEW_WADDR_BITS = 9;
	localparam int SEW_PAGE_BITS = 4;
	localparam int SEW_PAGE_BYTES = 16;
	localparam int SEW_PAGES = 32;
	localparam int SEW_MEM_BYTES = SEW_PAGES * SEW_PAGE_BYTES;

	// Device address word: fixed family pattern in the upper nibble
	localparam logic [3:0] SEW_FAMILY = 4'ha;

	// Bit counter values within one nine-clock word
	localparam logic [3:0] SEW_CNT_ACK = 4'h8;
	localparam logic [3:0] SEW_CNT_END = 4'h9;

	// Register map (byte addresses)
	localparam int SEW_AXI_AW = 8;
	localparam logic [7:0] SEW_REG_CTRL = 8'h00;
	localparam logic [7:0] SEW_REG_STATUS = 8'h04;
	localparam logic [7:0] SEW_REG_WRCNT = 8'h08;
	localparam logic [7:0] SEW_REG_LAST = 8'h0c;

	// Control register fields and reset value
	localparam int SEW_CTRL_EN = 0;
	localparam int SEW_CTRL_WPF = 1;
	localparam logic [1:0] SEW_CTRL_RST = 2'h1;

	// Status register fields
	localparam int SEW_ST_BUSY = 0;
	localparam int SEW_ST_FRAME = 1;
	localparam int SEW_ST_WP = 2;
	localparam int SEW_ST_ADDR = 4;
	localparam int SEW_ST_STATE = 16;

	// AXI responses
	localparam logic [1:0] SEW_RESP_OKAY = 2'h0;
	localparam logic [1:0] SEW_RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_DEV,
		ST_WADR,
		ST_WDAT,
		ST_RDAT,
		ST_PROG
	} sew_state_t;

endpackage

/* File: rtl/sew_eeprom_slave.sv */
// Purpose: Two-wire slave front end and access sequencer for a 512-byte
//   serial memory with 16-byte pages, plus an AXI4-Lite control port.
// Assumes: SCL, SDA, write-protect and straps come from outside the clock
//   domain; SCL is at least eight system clocks per period.
// Notes: SDA is open drain: sda_o is always low, sda_oe pulls the wire.
//
// Overview of operation
// - SDA falling with SCL high is start
// - SDA rising with SCL high is stop
// - SDA changes only while SCL is low
// - Eight-bit words, acknowledge low on ninth clock
// - Standby after power-up and after stop
// - Start followed by address word, family nibble
// - Two bits match straps, third selects half (here only taken with a word address; current-address reads ignore it)
// - Last address bit: one read, zero write
// - Acknowledge on match, otherwise back to standby
// - Byte write: address, word address, data, stop
// - Ignore bus during self-timed write cycle
// - Page write: up to sixteen bytes, each acknowledged
// - Page write increments in-page bits, wraps page
// - Acknowledge polling answered once write finished
// - Array is 32 pages of 16 bytes
// - Write-protect high blocks all array writes
// - Address counter holds last address plus one
// - Reads wrap whole array, writes wrap page
// - Random read: dummy write, repeated start, read
// - Sequential read continues while controller acknowledges
// - Sample on SCL rise, drive after SCL fall
// - Write period runs from stop to commit
//
// Design decisions made here: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps

module sew_eeprom_slave
	import sew_pkg::*;
#(
	parameter int PROG_CYCLES = SEW_PROG_CYC
) (
	input wire logic aclk, // System clock
	input wire logic aresetn, // Synchronous reset
	input wire logic [SEW_AXI_AW-1:0] s_axi_awaddr, // Write address
	input wire logic s_axi_awvalid, // Write address valid
	output logic s_axi_awready, // Write address ready
	input wire logic [31:0] s_axi_wdata, // Write data
	input wire logic [3:0] s_axi_wstrb, // Write byte strobes
	input wire logic s_axi_wvalid, // Write data valid
	output logic s_axi_wready, // Write data ready
	output logic [1:0] s_axi_bresp, // Write response
	output logic s_axi_bvalid, // Write response valid
	input wire logic s_axi_bready, // Write response ready
	input wire logic [SEW_AXI_AW-1:0] s_axi_araddr, // Read address
	input wire logic s_axi_arvalid, // Read address valid
	output logic s_axi_arready, // Read address ready
	output logic [31:0] s_axi_rdata, // Read data
	output logic [1:0] s_axi_rresp, // Read response
	output logic s_axi_rvalid, // Read data valid
	input wire logic s_axi_rready, // Read data ready
	input wire logic scl_i, // Serial clock pin
	input wire logic sda_i, // Serial data pin level
	output logic sda_o, // Serial data drive level
	output logic sda_oe, // Serial data pull-low enable
	input wire logic wp_i, // Write protect pin
	input wire logic device_select_strap_upper, // Upper select strap
	input wire logic device_select_strap_lower // Lower select strap
);

	localparam int PCW = $clog2(PROG_CYCLES + 1);

	logic [4:0] pin_m_ff;
	logic [4:0] pin_s_ff;
	logic scl_d_ff;
	logic sda_d_ff;
	logic scl_s;
	logic sda_s;
	logic wp_s;
	logic strap_u_s;
	logic strap_l_s;
	logic scl_rise;
	logic scl_fall;
	logic start_ev;
	logic stop_ev;

	sew_state_t state_ff;
	logic [3:0] cnt_ff;
	logic [7:0] sh_ff;
	logic [7:0] tx_ff;
	logic rw_ff;
	logic pg_ff;
	logic mack_ff;
	logic sda_oe_ff;
	logic [SEW_WADDR_BITS-1:0] addr_ff;
	logic [SEW_PAGE_BYTES-1:0] mask_ff;
	logic [7:0] buf_ff [SEW_PAGE_BYTES];
	logic [7:0] mem_ff [SEW_MEM_BYTES];
	logic [PCW-1:0] prog_cnt_ff;
	logic [15:0] wrcnt_ff;
	logic [7:0] last_ff;
	logic [1:0] ctrl_ff;

	logic serial_live;
	logic rx_ack_fall;
	logic word_end_fall;
	logic tx_load;
	logic dev_match;
	logic wp_eff;
	logic prog_done;
	logic [7:0] rd_byte;

	logic aw_go;
	logic ar_go;
	logic bvalid_ff;
	logic [1:0] bresp_ff;
	logic rvalid_ff;
	logic [31:0] rdata_ff;
	logic [1:0] rresp_ff;
	logic [31:0] nxt_rdata;
	logic nxt_rmapped;

	// Pins cross into aclk through two flops; only the second is read
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_m_ff <= 5'h03;
			pin_s_ff <= 5'h03;
		end else begin
			pin_m_ff <= {device_select_strap_lower, device_select_strap_upper,
				wp_i, sda_i, scl_i};
			pin_s_ff <= pin_m_ff;
		end
	end

	assign scl_s = pin_s_ff[0];
	assign sda_s = pin_s_ff[1];
	assign wp_s = pin_s_ff[2];
	assign strap_u_s = pin_s_ff[3];
	assign strap_l_s = pin_s_ff[4];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			scl_d_ff <= 1'b1;
			sda_d_ff <= 1'b1;
		end else begin
			scl_d_ff <= scl_s;
			sda_d_ff <= sda_s;
		end
	end

	assign scl_rise = scl_s & ~scl_d_ff;
	assign scl_fall = ~scl_s & scl_d_ff;
	assign start_ev = scl_s & scl_d_ff & ~sda_s & sda_d_ff;
	assign stop_ev = scl_s & scl_d_ff & sda_s & ~sda_d_ff;

	assign wp_eff = wp_s | ctrl_ff[SEW_CTRL_WPF];

	assign dev_match = (sh_ff[7:4] == SEW_FAMILY) &&
		(sh_ff[3] == strap_u_s) && (sh_ff[2] == strap_l_s) &&
		ctrl_ff[SEW_CTRL_EN];

	assign serial_live = (state_ff != ST_IDLE) && (state_ff != ST_PROG) &&
		!start_ev && !stop_ev;
	assign rx_ack_fall = serial_live && scl_fall && (cnt_ff == SEW_CNT_ACK) &&
		(state_ff != ST_RDAT);
	assign word_end_fall = serial_live && scl_fall && (cnt_ff == SEW_CNT_END);
	// next byte only after controller acknowledge
	assign tx_load = word_end_fall && (((state_ff == ST_DEV) && rw_ff) ||
		((state_ff == ST_RDAT) && mack_ff));
	assign rd_byte = mem_ff[addr_ff];
	assign prog_done = (state_ff == ST_PROG) &&
		(prog_cnt_ff == PCW'(PROG_CYCLES - 1));

	// Serial sequencer: framing, bit counting and SDA drive
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_ff <= ST_IDLE;
			cnt_ff <= 4'h0;
			sh_ff <= 8'h00;
			tx_ff <= 8'h00;
			rw_ff <= 1'b0;
			pg_ff <= 1'b0;
			mack_ff <= 1'b0;
			sda_oe_ff <= 1'b0;
		end else if (state_ff == ST_PROG) begin
			sda_oe_ff <= 1'b0;
			cnt_ff <= 4'h0;
			if (prog_done) begin
				state_ff <= ST_IDLE;
			end
		end else if (start_ev) begin
			state_ff <= ST_DEV;
			cnt_ff <= 4'h0;
			sda_oe_ff <= 1'b0;
		end else if (stop_ev) begin
			sda_oe_ff <= 1'b0;
			cnt_ff <= 4'h0;
			if ((state_ff == ST_WDAT) && (mask_ff != '0) && !wp_eff) begin
				state_ff <= ST_PROG;
			end else begin
				state_ff <= ST_IDLE;
			end
		end else if (state_ff == ST_IDLE) begin
			cnt_ff <= 4'h0;
			sda_oe_ff <= 1'b0;
		end else if (scl_rise) begin
			if (cnt_ff < SEW_CNT_ACK) begin
				sh_ff <= {sh_ff[6:0], sda_s};
				cnt_ff <= cnt_ff + 4'h1;
			end else if (cnt_ff == SEW_CNT_ACK) begin
				// controller acknowledge is a low SDA
				mack_ff <= ~sda_s;
				cnt_ff <= SEW_CNT_END;
			end
		end else if (scl_fall) begin
			if (state_ff == ST_RDAT) begin
				if ((cnt_ff != 4'h0) && (cnt_ff < SEW_CNT_ACK)) begin
					sda_oe_ff <= ~tx_ff[7];
					tx_ff <= {tx_ff[6:0], 1'b0};
				end else if (cnt_ff == SEW_CNT_ACK) begin
					sda_oe_ff <= 1'b0;
				end else if (cnt_ff == SEW_CNT_END) begin
					cnt_ff <= 4'h0;
					if (mack_ff) begin
						sda_oe_ff <= ~rd_byte[7];
						tx_ff <= {rd_byte[6:0], 1'b0};
					end else begin
						state_ff <= ST_IDLE;
					end
				end
			end else if (cnt_ff == SEW_CNT_ACK) begin
				if ((state_ff == ST_DEV) && !dev_match) begin
					// no match: release and stand by
					state_ff <= ST_IDLE;
				end else begin
					sda_oe_ff <= 1'b1;
				end
				if (state_ff == ST_DEV) begin
					rw_ff <= sh_ff[0];
					pg_ff <= sh_ff[1];
				end
			end else if (cnt_ff == SEW_CNT_END) begin
				sda_oe_ff <= 1'b0;
				cnt_ff <= 4'h0;
				case (state_ff)
					ST_DEV: begin
						if (rw_ff) begin
							state_ff <= ST_RDAT;
							sda_oe_ff <= ~rd_byte[7];
							tx_ff <= {rd_byte[6:0], 1'b0};
						end else begin
							state_ff <= ST_WADR;
						end
					end
					ST_WADR: begin
						state_ff <= ST_WDAT;
					end
					ST_WDAT: begin
						state_ff <= ST_WDAT;
					end
					default: begin
						state_ff <= ST_IDLE;
					end
				endcase
			end
		end
	end

	// Address counter and page buffer
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			addr_ff <= '0;
			mask_ff <= '0;
			last_ff <= 8'h00;
		end else begin
			if (start_ev && (state_ff != ST_PROG)) begin
				// A repeated start drops any unprogrammed page data
				mask_ff <= '0;
			end else if (prog_done) begin
				mask_ff <= '0;
			end else if (rx_ack_fall && (state_ff == ST_WADR)) begin
				addr_ff <= {pg_ff, sh_ff};
				last_ff <= sh_ff;
			end else if (rx_ack_fall && (state_ff == ST_WDAT)) begin
				addr_ff[SEW_PAGE_BITS-1:0] <=
					addr_ff[SEW_PAGE_BITS-1:0] + 4'h1;
				mask_ff[addr_ff[SEW_PAGE_BITS-1:0]] <= 1'b1;
				last_ff <= sh_ff;
			end else if (tx_load) begin
				addr_ff <= addr_ff + 9'h001;
			end else if (rx_ack_fall && (state_ff == ST_DEV)) begin
				last_ff <= sh_ff;
			end
		end
	end

	// overwrite on page wrap is natural here
	always_ff @(posedge aclk) begin
		if (rx_ack_fall && (state_ff == ST_WDAT)) begin
			buf_ff[addr_ff[SEW_PAGE_BITS-1:0]] <= sh_ff;
		end
	end

	// commit page at end of write period
	always_ff @(posedge aclk) begin
		if (prog_done) begin
			for (int i = 0; i < SEW_PAGE_BYTES; i++) begin
				if (mask_ff[i]) begin
					mem_ff[{addr_ff[SEW_WADDR_BITS-1:SEW_PAGE_BITS],
						SEW_PAGE_BITS'(i)}] <= buf_ff[i];
				end
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || (state_ff != ST_PROG)) begin
			prog_cnt_ff <= '0;
		end else begin
			prog_cnt_ff <= prog_cnt_ff + PCW'(1);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wrcnt_ff <= 16'h0000;
		end else if (prog_done) begin
			wrcnt_ff <= wrcnt_ff + 16'h0001;
		end
	end

	assign sda_o = 1'b0;
	assign sda_oe = sda_oe_ff;

	// Register write channel: address and data are taken together
	assign aw_go = s_axi_awvalid & s_axi_wvalid & ~bvalid_ff;
	assign s_axi_awready = aw_go;
	assign s_axi_wready = aw_go;
	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp = bresp_ff;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_ff <= 1'b0;
			bresp_ff <= SEW_RESP_OKAY;
		end else if (aw_go) begin
			bvalid_ff <= 1'b1;
			if ((s_axi_awaddr == SEW_REG_CTRL) ||
				(s_axi_awaddr == SEW_REG_STATUS) ||
				(s_axi_awaddr == SEW_REG_WRCNT) ||
				(s_axi_awaddr == SEW_REG_LAST)) begin
				bresp_ff <= SEW_RESP_OKAY;
			end else begin
				bresp_ff <= SEW_RESP_SLVERR;
			end
		end else if (s_axi_bready) begin
			bvalid_ff <= 1'b0;
		end
	end

	// Enable is taken immediately; a frame in flight sees it at next match
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_ff <= SEW_CTRL_RST;
		end else if (aw_go && (s_axi_awaddr == SEW_REG_CTRL) &&
			s_axi_wstrb[0]) begin
			ctrl_ff <= s_axi_wdata[1:0];
		end
	end

	// Register read channel
	assign ar_go = s_axi_arvalid & ~rvalid_ff;
	assign s_axi_arready = ~rvalid_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rdata = rdata_ff;
	assign s_axi_rresp = rresp_ff;

	always_comb begin
		nxt_rdata = 32'h0000_0000;
		nxt_rmapped = 1'b1;
		case (s_axi_araddr)
			SEW_REG_CTRL: begin
				nxt_rdata[1:0] = ctrl_ff;
			end
			SEW_REG_STATUS: begin
				nxt_rdata[SEW_ST_BUSY] = (state_ff == ST_PROG);
				nxt_rdata[SEW_ST_FRAME] = (state_ff != ST_IDLE) &&
					(state_ff != ST_PROG);
				nxt_rdata[SEW_ST_WP] = wp_eff;
				nxt_rdata[SEW_ST_ADDR +: SEW_WADDR_BITS] = addr_ff;
				nxt_rdata[SEW_ST_STATE +: 3] = state_ff;
			end
			SEW_REG_WRCNT: begin
				nxt_rdata[15:0] = wrcnt_ff;
			end
			SEW_REG_LAST: begin
				nxt_rdata[7:0] = last_ff;
			end
			default: begin
				nxt_rmapped = 1'b0;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h0000_0000;
			rresp_ff <= SEW_RESP_OKAY;
		end else if (ar_go) begin
			rvalid_ff <= 1'b1;
			rdata_ff <= nxt_rdata;
			rresp_ff <= nxt_rmapped ? SEW_RESP_OKAY : SEW_RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_ff <= 1'b0;
		end
	end

endmodule

/* File: test/sew_eeprom_slave_asserts.sv */
// Purpose: Port checks on the serial memory slave.
// Assumes: Bound to every slave instance.
// Notes: Frame flag decodes start and stop from pin levels.
`timescale 1ns/10ps
module sew_eeprom_slave_asserts
	import sew_pkg::*;
(
	input wire logic aclk, // clock
	input wire logic aresetn, // reset
	input wire logic [SEW_AXI_AW-1:0] s_axi_araddr, // ar addr
	input wire logic s_axi_awvalid, // aw valid
	input wire logic s_axi_awready, // aw ready
	input wire logic s_axi_wvalid, // w valid
	input wire logic s_axi_wready, // w ready
	input wire logic [1:0] s_axi_bresp, // b resp
	input wire logic s_axi_bvalid, // b valid
	input wire logic s_axi_bready, // b ready
	input wire logic s_axi_arvalid, // ar valid
	input wire logic s_axi_arready, // ar ready
	input wire logic [31:0] s_axi_rdata, // r data
	input wire logic [1:0] s_axi_rresp, // r resp
	input wire logic s_axi_rvalid, // r valid
	input wire logic s_axi_rready, // r ready
	input wire logic scl_i, // clock pin
	input wire logic sda_i, // data wire
	input wire logic sda_o, // drive level
	input wire logic sda_oe // pull enable
);
	logic frame_ff, sda_q_ff, scl_q_ff;
	always_ff @(posedge aclk) begin
		sda_q_ff <= sda_i;
		scl_q_ff <= scl_i;
	end
	// Clock must be high on both samples, else an edge race looks like a start
	always_ff @(posedge aclk) begin
		if (!aresetn)
			frame_ff <= 1'h0;
		else if (scl_i && scl_q_ff && sda_q_ff != sda_i)
			frame_ff <= sda_q_ff;
	end
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_wr_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_rd_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	a_wr_answer: assert property (s_wr_take |=> s_axi_bvalid)
		else $error("write not answered");
	a_wr_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
	a_wr_busy: assert property (s_axi_bvalid |-> !s_axi_awready)
		else $error("write taken while answering");
	a_rd_answer: assert property (s_rd_take |=> s_axi_rvalid)
		else $error("read not answered");
	a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
	a_rd_unmapped: assert property ((s_rd_take ##0 s_axi_araddr > SEW_REG_LAST)
		|=> s_axi_rresp == SEW_RESP_SLVERR) else $error("no slave error");
	a_open_drain: assert property (sda_o == 1'h0)
		else $error("data pin driven high");
	a_sda_steady: assert property (
		scl_i && $past(scl_i) |-> $stable(sda_oe))
		else $error("data moved while clock high");
	a_idle_quiet: assert property (!frame_ff |-> !sda_oe)
		else $error("data pulled outside a frame");
endmodule
bind sew_eeprom_slave sew_eeprom_slave_asserts u_chk (.aclk, .aresetn,
	.s_axi_araddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
	.s_axi_rvalid, .s_axi_rready, .scl_i, .sda_i, .sda_o, .sda_oe);

/* File: test/sew_ctl_model.sv */
// Purpose: Two-wire bus controller model.
// Assumes: 8 system clocks a bit, 4 low then 4 high.
// Notes: Only pulls data low; release leaves the pull-up.
`timescale 1ns/10ps
module sew_ctl_model (
	input wire logic aclk, // clock
	input wire logic sda, // data wire
	output logic scl, // serial clock
	output logic sda_oe // pull data low
);
	initial begin
		scl = 1'h1;
		sda_oe = 1'h0;
	end
	task automatic w(input int n);
		repeat (n) @(posedge aclk);
	endtask
	task automatic xbit(input logic b, output logic s);
		w(2);
		sda_oe <= !b;
		w(2);
		scl <= 1'h1;
		w(4);
		s = sda;
		scl <= 1'h0;
	endtask
	task automatic start;
		w(2);
		sda_oe <= 1'h0;
		w(2);
		scl <= 1'h1;
		w(4);
		sda_oe <= 1'h1;
		w(4);
		scl <= 1'h0;
	endtask
	task automatic stop;
		w(2);
		sda_oe <= 1'h1;
		w(2);
		scl <= 1'h1;
		w(4);
		sda_oe <= 1'h0;
		w(4);
	endtask
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			xbit(d[i], s);
		xbit(1'h1, s);
		ack = !s;
	endtask
	task automatic rbyte(input logic more, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			xbit(1'h1, s);
			d[i] = s;
		end
		xbit(!more, s);
	endtask
	// nine clocks, then start
	// A slave stuck mid-byte shifts out and sees no acknowledge
	task automatic recover(output logic free);
		logic s;
		free = 1'h0;
		for (int i = 0; i < 9; i++) begin
			xbit(1'h1, s);
			free = s;
		end
		start();
	endtask
endmodule

/* File: test/test_serial_eeprom_two_wire_slave.sv */
// Purpose: Self-checking bench for the serial memory slave.
// Assumes: Program period cut to PROG cycles.
// Notes: Array is unknown until written; only written bytes are read.
`timescale 1ns/10ps
module test_serial_eeprom_two_wire_slave
	import sew_pkg::*;
;
	localparam int PROG = 200;
	logic aclk = 1'h0, aresetn = 1'h0, awvalid = 1'h0, wvalid = 1'h0;
	logic bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic wp = 1'h0, su = 1'h1, sl = 1'h0;
	logic [7:0] awaddr = 8'h0, araddr = 8'h0;
	logic [31:0] wdata = 32'h0, rdata;
	logic awready, wready, bvalid, arready, rvalid, sda_o, sda_oe, scl, c_oe;
	logic [1:0] bresp, rresp;
	wire sda = (sda_oe || c_oe) ? 1'h0 : 1'h1;
	int n_errors = 0, total_checks = 0;
	always #10 aclk = ~aclk;
	sew_eeprom_slave #(.PROG_CYCLES(PROG)) DUT (.aclk, .aresetn,
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .scl_i(scl), .sda_i(sda), .sda_o, .sda_oe,
		.wp_i(wp), .device_select_strap_upper(su),
		.device_select_strap_lower(sl));
	sew_ctl_model CTL (.aclk, .sda, .scl, .sda_oe(c_oe));
	task automatic chk(input string what, input logic [31:0] e, g);
		total_checks++;
		if (g !== e) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic chk_ack(input string what, input logic e, g);
		chk(what, {31'h0, e}, {31'h0, g});
	endtask
	task automatic give_verdict;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		@(posedge aclk);
		while (awready !== 1'h1)
			@(posedge aclk);
		awvalid <= 1'h0;
		wvalid <= 1'h0;
		@(posedge aclk);
		while (bvalid !== 1'h1)
			@(posedge aclk);
		chk("bresp", {30'h0, a > SEW_REG_LAST ? SEW_RESP_SLVERR : 2'h0}, bresp);
		bready <= 1'h0;
		@(posedge aclk);
	endtask
	task automatic axr(input logic [7:0] a, output logic [31:0] d);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		@(posedge aclk);
		while (arready !== 1'h1)
			@(posedge aclk);
		arvalid <= 1'h0;
		@(posedge aclk);
		while (rvalid !== 1'h1)
			@(posedge aclk);
		d = rdata;
		chk("rresp", {30'h0, a > SEW_REG_LAST ? SEW_RESP_SLVERR : 2'h0}, rresp);
		rready <= 1'h0;
		@(posedge aclk);
	endtask
	task automatic dev(input logic [1:0] pr, output logic a);
		CTL.start();
		CTL.wbyte({SEW_FAMILY, su, sl, pr}, a);
	endtask
	task automatic wr(input logic [8:0] ad, input logic [7:0] d0, d1,
		input int n);
		logic a;
		dev({ad[8], 1'h0}, a);
		chk_ack("dev ack", 1'h1, a);
		CTL.wbyte(ad[7:0], a);
		chk_ack("word ack", 1'h1, a);
		CTL.wbyte(d0, a);
		chk_ack("data ack", 1'h1, a);
		if (n > 1) begin
			CTL.wbyte(d1, a);
			chk_ack("page ack", 1'h1, a);
		end
		CTL.stop();
	endtask
	task automatic poll(input logic busy);
		logic a;
		dev(2'h0, a);
		CTL.stop();
		chk_ack("first poll", !busy, a);
		for (int k = 0; k < 20 && !a; k++) begin
			dev(2'h0, a);
			CTL.stop();
		end
		chk_ack("poll ack", 1'h1, a);
	endtask
	task automatic rd(input logic [8:0] ad, input int n,
		output logic [7:0] d0, d1);
		logic a;
		dev({ad[8], 1'h0}, a);
		CTL.wbyte(ad[7:0], a);
		dev({ad[8], 1'h1}, a);
		chk_ack("read ack", 1'h1, a);
		CTL.rbyte(n > 1, d0);
		if (n > 1)
			CTL.rbyte(1'h0, d1);
		CTL.stop();
	endtask
	task automatic t_regs;
		logic [31:0] d;
		axr(SEW_REG_CTRL, d);
		chk("ctrl reset", {30'h0, SEW_CTRL_RST}, d);
		axr(8'h10, d);
		axw(8'h14, 32'h0);
	endtask
	task automatic t_addr;
		logic a;
		CTL.start();
		CTL.wbyte({SEW_FAMILY, su, !sl, 2'h0}, a);
		CTL.stop();
		chk_ack("strap mismatch", 1'h0, a);
		CTL.start();
		CTL.wbyte({4'h5, su, sl, 2'h0}, a);
		CTL.stop();
		chk_ack("family mismatch", 1'h0, a);
		sl <= 1'h1;
		@(posedge aclk);
		dev(2'h0, a);
		CTL.stop();
		chk_ack("strap moved", 1'h1, a);
		sl <= 1'h0;
		axw(SEW_REG_CTRL, 32'h0);
		dev(2'h0, a);
		CTL.stop();
		chk_ack("disabled", 1'h0, a);
		axw(SEW_REG_CTRL, 32'h1);
	endtask
	task automatic t_write;
		logic [31:0] d;
		wr(9'h1ff, 8'h3c, 8'hc5, 2);
		axr(SEW_REG_STATUS, d);
		chk("busy", 32'h1, {31'h0, d[SEW_ST_BUSY]});
		poll(1'h1);
		wr(9'h000, 8'h5a, 8'h00, 1);
		poll(1'h1);
		axr(SEW_REG_WRCNT, d);
		chk("write cycles", 32'h2, {16'h0, d[15:0]});
		// Last acked byte is the final poll's device address
		axr(SEW_REG_LAST, d);
		chk("last byte reg", {24'h0, SEW_FAMILY, su, sl, 2'h0}, d);
	endtask
	task automatic t_read;
		logic [7:0] d0, d1;
		logic a;
		rd(9'h1ff, 2, d0, d1);
		chk("last byte", 32'h3c, {24'h0, d0});
		chk("array wrap", 32'h5a, {24'h0, d1});
		rd(9'h1f0, 1, d0, d1);
		chk("page wrap", 32'hc5, {24'h0, d0});
		dev(2'h2, a);
		CTL.wbyte(8'hff, a);
		CTL.stop();
		dev(2'h1, a);
		chk_ack("no write cycle", 1'h1, a);
		CTL.rbyte(1'h0, d0);
		CTL.stop();
		chk("current read", 32'h3c, {24'h0, d0});
	endtask
	task automatic t_wp;
		logic [7:0] d0, d1;
		logic [31:0] d;
		wp <= 1'h1;
		wr(9'h000, 8'ha5, 8'h00, 1);
		poll(1'h0);
		wp <= 1'h0;
		// Software-forced protection must block the same way
		axw(SEW_REG_CTRL, 32'h3);
		axr(SEW_REG_STATUS, d);
		chk("protect flag", 32'h1, {31'h0, d[SEW_ST_WP]});
		wr(9'h000, 8'h96, 8'h00, 1);
		poll(1'h0);
		axw(SEW_REG_CTRL, 32'h1);
		rd(9'h000, 1, d0, d1);
		chk("protected byte", 32'h5a, {24'h0, d0});
	endtask
	task automatic t_recover;
		logic [7:0] d0;
		logic a, free;
		dev(2'h2, a);
		CTL.wbyte(8'hff, a);
		// Abandon a read while the slave still holds the bus
		dev(2'h3, a);
		CTL.recover(free);
		chk_ack("bus freed", 1'h1, free);
		CTL.wbyte({SEW_FAMILY, su, sl, 2'h1}, a);
		chk_ack("ack after recovery", 1'h1, a);
		CTL.rbyte(1'h0, d0);
		CTL.stop();
		chk("read after recovery", 32'h5a, {24'h0, d0});
	endtask
	initial begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'h1;
		repeat (4) @(posedge aclk);
		t_regs();
		t_addr();
		t_write();
		t_read();
		t_wp();
		t_recover();
		give_verdict();
	end
	initial begin
		#1000000;
		n_errors++;
		give_verdict();
	end
endmodule
